/* pmr_map.svh */
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH

// ****************************************
// Register numbers, user copies
// ****************************************
`define USER_EVENT_COUNTER_0 10'h000
`define USER_EVENT_COUNTER_1 10'h001
`define USER_EVENT_COUNTER_2 10'h002
`define USER_EVENT_COUNTER_3 10'h003
`define USER_COUNTER_CTRL_A_0 10'h080
`define USER_COUNTER_CTRL_A_1 10'h081
`define USER_COUNTER_CTRL_A_2 10'h082
`define USER_COUNTER_CTRL_A_3 10'h083
`define USER_COUNTER_CTRL_B_0 10'h100
`define USER_COUNTER_CTRL_B_1 10'h101
`define USER_COUNTER_CTRL_B_2 10'h102
`define USER_COUNTER_CTRL_B_3 10'h103
`define USER_GLOBAL_MONITOR_CTRL 10'h180

// ****************************************
// Register numbers, supervisor level
// ****************************************
`define EVENT_COUNTER_0 10'h010
`define EVENT_COUNTER_1 10'h011
`define EVENT_COUNTER_2 10'h012
`define EVENT_COUNTER_3 10'h013
`define COUNTER_CTRL_A_0 10'h090
`define COUNTER_CTRL_A_1 10'h091
`define COUNTER_CTRL_A_2 10'h092
`define COUNTER_CTRL_A_3 10'h093
`define COUNTER_CTRL_B_0 10'h110
`define COUNTER_CTRL_B_1 10'h111
`define COUNTER_CTRL_B_2 10'h112
`define COUNTER_CTRL_B_3 10'h113
`define GLOBAL_MONITOR_CTRL 10'h190

// ****************************************
// Field layout of a register number
// ****************************************
`define NUM_GROUP_MSB 9
`define NUM_GROUP_LSB 5
`define NUM_SUP_BIT 4
`define GROUP_COUNTER 5'h00
`define GROUP_CTRL_A 5'h04
`define GROUP_CTRL_B 5'h08
`define GROUP_GLOBAL 5'h0C

// ****************************************
// Storage slots and reset value
// ****************************************
`define SLOT_COUNTER 4'h0
`define SLOT_CTRL_A 4'h4
`define SLOT_CTRL_B 4'h8
`define SLOT_GLOBAL 4'hC
`define MON_REG_RESET 32'h0000_0000

`endif

/* pmr_pkg.sv */
`default_nettype none

package pmr_pkg;

    // Instruction kind presented by the pipeline
    typedef enum logic [1:0] {
        OP_OTHER = 2'b00,
        OP_MOVE_FROM = 2'b01,
        OP_MOVE_TO = 2'b10
    } mon_op_t;

    // One access from the execute stage
    typedef struct packed {
        mon_op_t op;
        logic [9:0] monitor_reg_number;
        logic [31:0] data;
        logic userMode;
    } mon_req_t;

    // Answer one cycle later
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic privExc;
        logic illegalExc;
    } mon_resp_t;

    // Decoded register number
    typedef struct packed {
        logic hit;
        logic userCopy;
        logic [3:0] slot;
    } mon_dec_t;

endpackage : pmr_pkg
`default_nettype wire

/* pmr_decode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.svh"

module pmr_decode
    import pmr_pkg::*;
(
    // Register number in, decoded slot out
    input wire logic [9:0] num,
    output mon_dec_t dec
);

    // ****************************************
    // Number to slot mapping
    // ****************************************
    // Two 5-bit fields: group above, lane and level below
    function automatic mon_dec_t decodeNum(input logic [9:0] n);
        mon_dec_t d;
        logic [4:0] grp;
        logic [4:0] low;
        d = '0;
        grp = n[`NUM_GROUP_MSB:`NUM_GROUP_LSB];
        low = n[4:0];
        // Level bit set means supervisor, clear means the user copy
        d.userCopy = ~low[`NUM_SUP_BIT];
        case (grp)
            `GROUP_COUNTER: begin
                d.hit = (low[3:2] == 2'h0);
                d.slot = `SLOT_COUNTER | {2'h0, low[1:0]};
            end
            `GROUP_CTRL_A: begin
                d.hit = (low[3:2] == 2'h0);
                d.slot = `SLOT_CTRL_A | {2'h0, low[1:0]};
            end
            `GROUP_CTRL_B: begin
                d.hit = (low[3:2] == 2'h0);
                d.slot = `SLOT_CTRL_B | {2'h0, low[1:0]};
            end
            `GROUP_GLOBAL: begin
                // Only lane 0 exists here
                d.hit = (low[3:0] == 4'h0);
                d.slot = `SLOT_GLOBAL;
            end
            default: begin
                // Outside every group: nothing answers here
                d.hit = 1'b0;
            end
        endcase
        return d;
    endfunction : decodeNum

    // Pure combinational decode
    assign dec = decodeNum(num);

endmodule : pmr_decode
`default_nettype wire

/* pmr_store.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.svh"

module pmr_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Write port
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrIdx,
    input wire logic [WIDTH-1:0] wrData,
    // Read port, data registered
    input wire logic rdEn,
    input wire logic [$clog2(DEPTH)-1:0] rdIdx,
    output logic [WIDTH-1:0] rdData_r
);

    // Word storage
    logic [WIDTH-1:0] mem [DEPTH];

    // ****************************************
    // Write and clear
    // ****************************************
    // Cleared on reset so reads are never unknown
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= WIDTH'(`MON_REG_RESET);
            end
        end else if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    // ****************************************
    // Registered read
    // ****************************************
    // Zero when no legal read, so stale data never leaks
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdData_r <= '0;
        end else if (rdEn) begin
            rdData_r <= mem[rdIdx];
        end else begin
            rdData_r <= '0;
        end
    end

endmodule : pmr_store
`default_nettype wire

/* perf_monitor_reg_access.sv */
// Behaviour
// - Only monitor move instructions reach this space
// - User mode supervisor access gives privilege exception
// - User copies read-only, read by move-from
// - Any write to user copy is illegal
// - Number 400 maps to global control
// - 144-147 control a, 272-275 control b
// - 16-19 map to counters 0-3
// - User copies at 384, 128-131, 256-259
// - Numbers 0-3 are user counter copies
// - User low field clears supervisor low MSB
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.svh"

module perf_monitor_reg_access
    import pmr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Request from the execute stage
    input wire logic reqValid,
    input wire mon_req_t req,
    // Answer to the pipeline
    output mon_resp_t resp,
    // Global control for the counting logic
    output logic [31:0] globalCtrl
);

    // ****************************************
    // Declarations
    // ****************************************
    mon_dec_t dec;              // Decoded register number
    logic isMonOp;              // One of the two monitor moves
    logic isWrite;              // Move-to
    logic accept;               // Request this block answers
    logic illegal;              // Illegal-instruction case
    logic priv;                 // Privilege case
    logic wrEn;                 // Legal write to storage
    logic rdEn;                 // Legal read from storage
    logic respValid_r;          // Answer strobe
    logic privExc_r;            // Privilege exception flag
    logic illegalExc_r;         // Illegal-instruction flag
    logic [31:0] rdData;        // Registered read word
    logic [31:0] globalCtrl_r;  // Local copy of global control

    // ****************************************
    // Decode
    // ****************************************
    // Both levels share one slot, so a copy needs no storage
    pmr_decode u_decode (
        .num(req.monitor_reg_number),
        .dec(dec)
    );

    // ****************************************
    // Access checks
    // ****************************************
    // Ordinary special register moves are not answered here
    assign isMonOp = (req.op == OP_MOVE_FROM) || (req.op == OP_MOVE_TO);
    assign isWrite = (req.op == OP_MOVE_TO);
    assign accept = reqValid && isMonOp;

    // Illegal beats privilege: no number or a copy write
    always_comb begin
        illegal = 1'b0;
        if (accept) begin
            if (!dec.hit) begin
                illegal = 1'b1;
            end else if (dec.userCopy && isWrite) begin
                // Regardless of mode
                illegal = 1'b1;
            end
        end
    end

    // User mode may touch only the read-only copies
    assign priv = accept && !illegal && req.userMode && !dec.userCopy;

    // Suppressed accesses move nothing
    assign wrEn = accept && isWrite && !illegal && !priv;
    assign rdEn = accept && !isWrite && !illegal && !priv;

    // ****************************************
    // Storage
    // ****************************************
    // Copy reads hit the supervisor slot, always current
    pmr_store #(
        .WIDTH(32),
        .DEPTH(16)
    ) u_store (
        .mclk(mclk),
        .resetn(resetn),
        .wrEn(wrEn),
        .wrIdx(dec.slot),
        .wrData(req.data),
        .rdEn(rdEn),
        .rdIdx(dec.slot),
        .rdData_r(rdData)
    );

    // ****************************************
    // Global control mirror
    // ****************************************
    // Kept as flops so counting logic sees all bits at once
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            globalCtrl_r <= `MON_REG_RESET;
        end else if (wrEn && (dec.slot == `SLOT_GLOBAL)) begin
            globalCtrl_r <= req.data;
        end
    end

    // ****************************************
    // Answer strobe
    // ****************************************
    // One answer per accepted request, next cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            respValid_r <= 1'b0;
        end else begin
            respValid_r <= accept;
        end
    end

    // ****************************************
    // Exception flags
    // ****************************************
    // Pulses aligned with the answer strobe
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            privExc_r <= 1'b0;
            illegalExc_r <= 1'b0;
        end else begin
            privExc_r <= priv;
            illegalExc_r <= illegal;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign resp.valid = respValid_r;
    assign resp.data = rdData;
    assign resp.privExc = privExc_r;
    assign resp.illegalExc = illegalExc_r;
    assign globalCtrl = globalCtrl_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Legal write followed by a read of the same slot
    sequence s_write_slot;
        wrEn;
    endsequence

    sequence s_read_back;
        rdEn && !wrEn && (dec.slot == $past(dec.slot));
    endsequence

    // Helper: supervisor target from user mode
    logic userOnSup;
    assign userOnSup = accept && dec.hit && !dec.userCopy && req.userMode;

    a_spr_ignored: assert property (
        (reqValid && !isMonOp) |=> !resp.valid && !resp.privExc && !resp.illegalExc)
        else $error("non-monitor move was answered");

    a_priv_raised: assert property (
        userOnSup |=> resp.valid && resp.privExc && !resp.illegalExc && (resp.data == 32'h0000_0000))
        else $error("user access to supervisor register not trapped");

    a_priv_no_store: assert property (
        (userOnSup && isWrite) |=> $stable(globalCtrl))
        else $error("trapped write changed global control");

    a_copy_read_ok: assert property (
        (accept && !isWrite && dec.hit && dec.userCopy) |=> resp.valid && !resp.privExc && !resp.illegalExc)
        else $error("read of user copy refused");

    a_copy_write_illegal: assert property (
        (accept && isWrite && dec.hit && dec.userCopy) |-> !wrEn ##1 (resp.illegalExc && !resp.privExc))
        else $error("write to user copy not illegal");

    a_global_map: assert property (
        (accept && req.monitor_reg_number == `GLOBAL_MONITOR_CTRL && isWrite && !req.userMode)
        |=> (globalCtrl == $past(req.data)) && !resp.illegalExc)
        else $error("global control write lost");

    a_ctrl_map: assert property (
        (accept && req.monitor_reg_number >= `COUNTER_CTRL_A_0 && req.monitor_reg_number <= `COUNTER_CTRL_A_3)
        |-> dec.hit && !dec.userCopy && dec.slot[3:2] == 2'h1
        && dec.slot[1:0] == req.monitor_reg_number[1:0])
        else $error("control a decode wrong");

    a_ctrl_b_map: assert property (
        (accept && req.monitor_reg_number >= `COUNTER_CTRL_B_0 && req.monitor_reg_number <= `COUNTER_CTRL_B_3)
        |-> dec.hit && !dec.userCopy && dec.slot[3:2] == 2'h2)
        else $error("control b decode wrong");

    a_counter_map: assert property (
        (accept && req.monitor_reg_number >= `EVENT_COUNTER_0 && req.monitor_reg_number <= `EVENT_COUNTER_3)
        |-> dec.hit && !dec.userCopy && dec.slot == {2'h0, req.monitor_reg_number[1:0]})
        else $error("counter decode wrong");

    a_user_ctrl_map: assert property (
        (accept && (req.monitor_reg_number == `USER_GLOBAL_MONITOR_CTRL
        || req.monitor_reg_number == `USER_COUNTER_CTRL_A_0 || req.monitor_reg_number == `USER_COUNTER_CTRL_B_3))
        |-> dec.hit && dec.userCopy)
        else $error("user control copy decode wrong");

    a_user_counter_map: assert property (
        (accept && req.monitor_reg_number <= `USER_EVENT_COUNTER_3)
        |-> dec.hit && dec.userCopy && dec.slot == {2'h0, req.monitor_reg_number[1:0]})
        else $error("user counter decode wrong");

    a_level_bit: assert property (
        (accept && dec.hit) |-> (dec.userCopy == !req.monitor_reg_number[4]))
        else $error("level bit not honoured");

    a_copy_current: assert property (
        s_write_slot ##1 s_read_back |=> resp.data == $past(req.data, 2))
        else $error("read did not return last written value");

    a_unmapped_illegal: assert property (
        (accept && !dec.hit) |-> !wrEn ##1 (resp.valid && resp.illegalExc && !resp.privExc))
        else $error("unmapped number not illegal");

    // ****************************************
    // Answer and suppression checks
    // ****************************************
    // Taken requests not yet answered; a stuck or doubled strobe shows here
    logic [1:0] owedCount_r;

    // Helper count, wraps on an answer without a request
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            owedCount_r <= 2'h0;
        end else begin
            owedCount_r <= owedCount_r + 2'(accept) - 2'(respValid_r);
        end
    end

    // Read of global control through either level
    sequence s_global_read;
        rdEn && (dec.slot == `SLOT_GLOBAL);
    endsequence

    // At most one answer owed at any time
    a_owed_bounded: assert property (
        owedCount_r <= 2'h1)
        else $error("answer count out of step with requests");

    // Every taken request answered on the next edge
    a_answer_next: assert property (
        accept |=> resp.valid)
        else $error("taken request not answered next cycle");

    // No answer without a taken request
    a_no_stray_answer: assert property (
        !accept |=> !resp.valid)
        else $error("answer without a taken request");

    // Exceptions only with an answer, never both
    a_exc_exclusive: assert property (
        (resp.privExc || resp.illegalExc) |-> resp.valid && !(resp.privExc && resp.illegalExc))
        else $error("exception without answer or both raised");

    // Supervisor mode reads its own registers freely
    a_sup_read_ok: assert property (
        (accept && !isWrite && dec.hit && !dec.userCopy && !req.userMode)
        |=> resp.valid && !resp.privExc && !resp.illegalExc)
        else $error("supervisor read wrongly trapped");

    // Only a move-from returns register contents
    a_write_no_data: assert property (
        (accept && isWrite) |=> (resp.data == 32'h0000_0000))
        else $error("write returned read data");

    // Refused copy write leaves global control alone
    a_copy_write_kept: assert property (
        (accept && isWrite && dec.userCopy && (dec.slot == `SLOT_GLOBAL)) |=> $stable(globalCtrl))
        else $error("write to user copy changed global control");

    // User global copy shares the global slot
    a_user_global_map: assert property (
        (accept && req.monitor_reg_number == `USER_GLOBAL_MONITOR_CTRL)
        |-> dec.hit && dec.userCopy && (dec.slot == `SLOT_GLOBAL))
        else $error("user global copy decode wrong");

    // Storage and the mirror must agree on every global control read
    a_global_copy_read: assert property (
        s_global_read |=> (resp.data == $past(globalCtrl)))
        else $error("global read differs from live control");

    // Unmapped access changes nothing
    a_unmapped_kept: assert property (
        (accept && !dec.hit) |=> $stable(globalCtrl))
        else $error("unmapped access changed global control");

endmodule : perf_monitor_reg_access
`default_nettype wire

/* pmr_pipe_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Execute stage model
// ****************************************
module pmr_pipe_model
    import pmr_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Request to the monitor block
    output logic reqValid,
    output mon_req_t req
);

    // Idle at time zero with every field set to ones
    initial begin
        reqValid = 1'b0;
        req = '1;
    end

    // One move instruction, held up to and through the taking edge
    task automatic issue(input mon_op_t op, input logic [9:0] num, input logic [31:0] d, input logic user);
        reqValid <= 1'b1;
        req <= '{op: op, monitor_reg_number: num, data: d, userMode: user};
        @(posedge mclk);
    endtask : issue

    // Release; fields inverted so a stale word never looks like a request
    task automatic idle();
        reqValid <= 1'b0;
        req <= ~req;
    endtask : idle

endmodule : pmr_pipe_model

`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import pmr_pkg::*;

    // ****************************************
    // Signals and scoreboard
    // ****************************************
    logic mclk; // 50 MHz core clock
    logic resetn; // Synchronous, active low
    logic reqValid;
    mon_req_t req;
    mon_resp_t resp;
    logic [31:0] globalCtrl;
    logic [31:0] shadow [16]; // Expected contents by slot
    int miscompares;
    int checks;
    logic [3:0] kk;
    logic [9:0] num;
    logic [31:0] dat;
    logic [9:0] badNums [6] = '{10'h004, 10'h014, 10'h191, 10'h1A0, 10'h3FF, 10'h08C};

    // Clock generator
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Far side of the request port
    pmr_pipe_model i_pipe (.mclk(mclk), .reqValid(reqValid), .req(req));

    perf_monitor_reg_access i_dut (
        .mclk(mclk),
        .resetn(resetn),
        .reqValid(reqValid),
        .req(req),
        .resp(resp),
        .globalCtrl(globalCtrl)
    );

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic compare(input string name, input logic [34:0] seen, input logic [34:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : compare

    // Slot of a number, -1 when unmapped; kept apart from the design decoder
    function automatic int slot_of(input logic [9:0] n);
        if (n[3:2] != 2'b00) return -1;
        case (n[9:5])
            5'h00: return int'(n[1:0]);
            5'h04: return 4 + int'(n[1:0]);
            5'h08: return 8 + int'(n[1:0]);
            5'h0C: return (n[1:0] == 2'b00) ? 12 : -1;
            default: return -1;
        endcase
    endfunction : slot_of

    // Mapped number of slot k; sup selects the supervisor copy
    function automatic logic [9:0] num_of(input logic [3:0] k, input logic sup);
        return {1'b0, k[3:2], 2'b00, sup, 2'b00, k[1:0]};
    endfunction : num_of

    // One access with its full expected answer
    task automatic access(input mon_op_t op, input logic [9:0] n, input logic [31:0] d, input logic user);
        mon_resp_t exp;
        int s;
        s = slot_of(n);
        exp = '0;
        exp.valid = (op != OP_OTHER);
        // Illegal wins over privilege
        if (!exp.valid) begin
        end else if (s < 0 || (op == OP_MOVE_TO && !n[4])) begin
            exp.illegalExc = 1'b1;
        end else if (user && n[4]) begin
            exp.privExc = 1'b1;
        end else if (op == OP_MOVE_FROM) begin
            exp.data = shadow[s];
        end
        i_pipe.issue(op, n, d, user);
        i_pipe.idle();
        #1;
        if (exp.valid) begin
            compare("resp", resp, exp);
        end else begin
            compare("resp.valid", {34'b0, resp.valid}, 35'h0);
        end
        if (exp.valid && !exp.illegalExc && !exp.privExc && op == OP_MOVE_TO) begin
            shadow[s] = d;
        end
        compare("globalCtrl", {3'b0, globalCtrl}, {3'b0, shadow[12]});
        // Back on an edge so the next request is launched there
        @(posedge mclk);
    endtask : access

    // Verdict, the only exit
    task automatic finish_test();
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        miscompares = 0;
        checks = 0;
        foreach (shadow[i]) shadow[i] = 32'h0000_0000;
        void'($urandom(76065));
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        // Every register: reset value, both copies, both modes
        for (int k = 0; k < 13; k++) begin
            kk = k[3:0];
            dat = $urandom();
            access(OP_MOVE_FROM, num_of(kk, 1'b1), 32'h0, 1'b0);
            access(OP_MOVE_TO, num_of(kk, 1'b1), dat, 1'b0);
            access(OP_MOVE_FROM, num_of(kk, 1'b0), 32'h0, 1'b1);
            access(OP_MOVE_TO, num_of(kk, 1'b0), ~dat, 1'b0);
            access(OP_MOVE_TO, num_of(kk, 1'b0), ~dat, 1'b1);
            access(OP_MOVE_FROM, num_of(kk, 1'b1), 32'h0, 1'b1);
            access(OP_MOVE_TO, num_of(kk, 1'b1), ~dat, 1'b1);
            access(OP_MOVE_FROM, num_of(kk, 1'b0), 32'h0, 1'b0);
        end
        // Holes in the map, both modes
        foreach (badNums[i]) begin
            access(OP_MOVE_TO, badNums[i], 32'hFFFF_FFFF, 1'b0);
            access(OP_MOVE_FROM, badNums[i], 32'h0, 1'b1);
        end
        // Ordinary instruction at a mapped number is ignored
        access(OP_OTHER, 10'h190, 32'h1234_5678, 1'b0);
        // Back to back: write then user copy read in the next cycle
        dat = $urandom();
        i_pipe.issue(OP_MOVE_TO, 10'h111, dat, 1'b0);
        i_pipe.issue(OP_MOVE_FROM, 10'h101, 32'h0, 1'b1);
        i_pipe.idle();
        #1;
        shadow[9] = dat;
        compare("b2b read", resp, {1'b1, dat, 2'b00});
        @(posedge mclk);
        // Random traffic with random gaps
        repeat (400) begin
            num = $urandom_range(0, 1) ? num_of(4'($urandom_range(0, 12)), 1'($urandom())) : 10'($urandom());
            access(mon_op_t'($urandom_range(0, 2)), num, $urandom(), 1'($urandom()));
            repeat ($urandom_range(0, 2)) @(posedge mclk);
        end
        // Reset in mid-run clears every register
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        compare("resp in reset", resp, 35'h0);
        compare("globalCtrl in reset", {3'b0, globalCtrl}, 35'h0);
        // Release on an edge, first request one cycle later
        @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        foreach (shadow[i]) shadow[i] = 32'h0000_0000;
        for (int k = 0; k < 13; k++) begin
            access(OP_MOVE_FROM, num_of(k[3:0], 1'b0), 32'h0, 1'b1);
        end
        finish_test();
    end

endmodule : testbench

`default_nettype wire
